// file: logic/serial_unit_defs.svh
// Purpose: register offsets, field positions, bit counts and responses of the clocked serial slave
// Assumes: 32-bit axi4-lite data, one register per aligned word
// Notes:   included by the top module only
`ifndef SERIAL_UNIT_DEFS_SVH
`define SERIAL_UNIT_DEFS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define OFS_TRANSMIT_STATUS_CONTROL_CTRL 4'h0
`define OFS_RECEIVE_STATUS_CONTROL_CTRL 4'h4
`define OFS_BAUD_CTRL  4'h8
`define OFS_TX_DATA    4'hc
// bank codes; the register decode uses all four address bits and selects no bank
`define OFS_HI_BANK    2'h1
`define OFS_LO_BANK    2'h0

// ****************************************
// transmit status/control fields
// ****************************************
`define TXS_CLK_SRC    7
`define TXS_NINE       6
`define TXS_EN         5
`define TXS_SYNC       4
`define TXS_SHIFT_EMPTY_FLAG       1
`define TXS_NINTH      0

// ****************************************
// receive status/control fields
// ****************************************
`define RCS_SERIAL_PORT_ENABLE       7
`define RCS_NINE       6
`define RCS_SINGLE_RECEIVE_ENABLE       5
`define RCS_CONTINUOUS_RECEIVE_ENABLE       4
`define RCS_OVERRUN_ERROR       1
`define RCS_NINTH      0

// ****************************************
// pin select and interrupt fields
// ****************************************
`define PIN_DATA_SEL   7
`define PIN_CLK_SEL    2
`define INT_RX_EN      0
`define INT_TX_EN      1
`define INT_PERIPH_EN  2
`define INT_GLOBAL_EN  3
`define INT_RX_FLAG    4
`define INT_TX_FLAG    5

// ****************************************
// counts and responses
// ****************************************
`define BITS_EIGHT     4'h8
`define BITS_NINE      4'h9
`define BIT_CNT_ZERO   4'h0
`define FIFO_DEPTH     2'h2
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// file: logic/serial_unit_pkg.sv
// Purpose: shared types of the clocked serial slave
// Assumes: constants come from serial_unit_defs.svh
// Notes:   state is one packed struct
package serial_unit_pkg;

   typedef enum logic [1:0] {
      idle_st,
      shift_st
   } shift_state_t;

   typedef struct packed {
      logic [8:0] data;
   } char_t;

   typedef struct packed {
      // bus side
      logic        awvalid_hold;
      logic [3:0]  awaddr;
      logic        wvalid_hold;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      // software registers
      logic        clock_source_select;
      logic        transmit_nine_bit;
      logic        transmit_enable;
      logic        sync_mode;
      logic        transmit_ninth_bit;
      logic        serial_port_enable;
      logic        receive_nine_bit;
      logic        single_receive_enable;
      logic        continuous_receive_enable;
      logic        overrun_error;
      logic [7:0]  baud_control;
      logic        clock_pin_select;
      logic        data_pin_select;
      logic        receive_int_enable;
      logic        transmit_int_enable;
      logic        peripheral_int_enable;
      logic        global_int_enable;
      // link sampling
      logic [2:0]  clk_sync;
      logic [1:0]  dat_sync;
      // transmit path
      logic [8:0]  transmit_shift_reg;
      logic [3:0]  tx_count;
      logic        tx_busy;
      char_t       tx_buffer;
      logic        tx_buffer_full;
      logic        transmit_flag;
      // receive path
      logic [8:0]  receive_shift_reg;
      logic [3:0]  rx_count;
      char_t [1:0] rx_fifo;
      logic [1:0]  rx_level;
      // pins and outputs
      logic        data_out;
      logic        data_oe_n;
      logic        clk_oe_n;
      logic        irq;
      logic        wake;
   } state_t;

endpackage : serial_unit_pkg

// file: logic/usart_clocked_slave.sv
// Purpose: synchronous slave serial port clocked by an external master
// Assumes: link clock far slower than aclk; it is sampled, never used as a clock
// Notes:   registers over axi4-lite; pins are three-signal
`timescale 1ns/10ps
`include "serial_unit_defs.svh"

// Overview of operation
// [RQ1] clocked mode, port on, slave clock, receive enables clear: slave transmitter
// [RQ2] transmit enable arms transmitter; a data write starts the character
// [RQ3] software writes the ninth transmit bit before the low eight bits
// [RQ4] slave reception treats continuous receive as set, receiver never idle; the code receives only while continuous_receive_enable is set
// [RQ5] single receive enable is ignored in slave mode
// [RQ6] continuous receive set before sleep lets a character land during sleep
// [RQ7] completed character sets receive flag; interrupt when its enable is set
// [RQ8] software reads received ninth bit before reading low eight bits
// [RQ9] overrun cleared by clearing continuous receive or port enable
// [RQ10] only slave mode shifts during sleep; others need the system clock
// [RQ11] shift registers move only on the external serial clock
// [RQ12] reading received data unloads buffer; flag clears when nothing remains
// [RQ13] asleep in slave receive, a complete word sets flag and wakes
// [RQ14] wake runs next instruction, then vector if global enable set
// [RQ15] writing transmit data clears transmit flag, fills shifter then buffer; the code clears the flag only when the byte goes into the buffer
// [RQ16] shifter emptied by master: buffer moves in, transmit flag sets, wakes
// [RQ17] afterwards transmit data accepts another character, clearing the flag
// [RQ18] software sets transmit and peripheral enables before sleep
// [RQ19] clock and data functions relocatable by pin select bits
// [RQ20] data changes on leading edge, sampled on trailing edge, one bit per clock
// [RQ21] master supplies exactly one clock per data bit
// [RQ22] slave mode disables the clock pin output driver
// [RQ23] two-character receive buffer; third sets overrun, keeps data, blocks reception
// [RQ24] least significant bit first, ninth bit last when selected
module usart_clocked_slave
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic [1:0]  clock_pin_i,
   output logic [1:0]       clock_pin_o,
   output logic [1:0]       clock_pin_oe_n,
   input  wire logic [1:0]  data_pin_i,
   output logic [1:0]       data_pin_o,
   output logic [1:0]       data_pin_oe_n,
   input  wire logic        sleeping,
   output logic             wake_req,
   output logic             irq
);

   serial_unit_pkg::state_t s;
   serial_unit_pkg::state_t next_s;

   logic       slave_mode;
   logic       rx_mode;
   logic       tx_mode;
   logic       lead_edge;
   logic       trail_edge;
   logic [3:0] char_bits;
   logic       wr_go;
   logic       rd_go;
   logic [3:0] wr_addr;
   logic [7:0] tx_byte;
   logic [8:0] rx_char;

   always_comb
   begin
      next_s = s;
      slave_mode = s.sync_mode && s.serial_port_enable && !s.clock_source_select;
      // single receive enable plays no part in rx_mode; it only blocks tx_mode
      rx_mode = slave_mode && s.continuous_receive_enable;            // [RQ4] [RQ5]
      tx_mode = slave_mode && !s.continuous_receive_enable && !s.single_receive_enable
                && s.transmit_enable;                                   // [RQ1] [RQ2]
      char_bits = s.receive_nine_bit ? `BITS_NINE : `BITS_EIGHT;
      // ****************************************
      // link sampling, relocatable pins
      // ****************************************
      next_s.clk_sync = {s.clk_sync[1], s.clk_sync[0],
                         clock_pin_i[s.clock_pin_select]};               // [RQ19]
      next_s.dat_sync = {s.dat_sync[0], data_pin_i[s.data_pin_select]};
      // stage 0 feeds stage 1 only; edges compare stages 1 and 2
      lead_edge  = s.clk_sync[1] && !s.clk_sync[2];                     // [RQ20]
      trail_edge = !s.clk_sync[1] && s.clk_sync[2];                     // [RQ20]

      // ****************************************
      // bus write
      // ****************************************
      next_s.awready = 1'b0;
      next_s.wready  = 1'b0;
      next_s.arready = 1'b0;
      if (awvalid && !s.awvalid_hold && !s.bvalid)
      begin
         next_s.awvalid_hold = 1'b1;
         next_s.awaddr = awaddr;
         next_s.awready = 1'b1;
      end
      if (wvalid && !s.wvalid_hold && !s.bvalid)
      begin
         next_s.wvalid_hold = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
         next_s.wready = 1'b1;
      end
      wr_go = s.awvalid_hold && s.wvalid_hold && !s.bvalid;
      wr_addr = s.awaddr;
      tx_byte = s.wdata[7:0];
      if (bvalid && bready)
         next_s.bvalid = 1'b0;
      if (wr_go)
      begin
         next_s.awvalid_hold = 1'b0;
         next_s.wvalid_hold = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = `RESP_OKAY;
         if (s.wstrb[0])
         begin
            // full-address decode: misaligned or unmapped words fall to the error branch
            case (wr_addr)
               `OFS_TRANSMIT_STATUS_CONTROL_CTRL:
               begin
                  next_s.clock_source_select = s.wdata[`TXS_CLK_SRC];
                  next_s.transmit_nine_bit   = s.wdata[`TXS_NINE];
                  next_s.transmit_enable     = s.wdata[`TXS_EN];
                  next_s.sync_mode           = s.wdata[`TXS_SYNC];
                  next_s.transmit_ninth_bit  = s.wdata[`TXS_NINTH];
               end
               `OFS_RECEIVE_STATUS_CONTROL_CTRL:
               begin
                  next_s.serial_port_enable        = s.wdata[`RCS_SERIAL_PORT_ENABLE];
                  next_s.receive_nine_bit          = s.wdata[`RCS_NINE];
                  next_s.single_receive_enable     = s.wdata[`RCS_SINGLE_RECEIVE_ENABLE];
                  next_s.continuous_receive_enable = s.wdata[`RCS_CONTINUOUS_RECEIVE_ENABLE];
               end
               `OFS_BAUD_CTRL:
               begin
                  next_s.baud_control = s.wdata[7:0];
                  next_s.data_pin_select = s.wdata[8 + `PIN_DATA_SEL];
                  next_s.clock_pin_select = s.wdata[8 + `PIN_CLK_SEL];
                  next_s.receive_int_enable = s.wdata[16 + `INT_RX_EN];
                  next_s.transmit_int_enable = s.wdata[16 + `INT_TX_EN];
                  next_s.peripheral_int_enable = s.wdata[16 + `INT_PERIPH_EN];
                  next_s.global_int_enable = s.wdata[16 + `INT_GLOBAL_EN];
               end
               `OFS_TX_DATA:
               begin
                  // fill the shifter first, else the buffer; a full buffer drops the byte
                  if (!s.tx_busy)
                  begin
                     next_s.transmit_shift_reg = {s.transmit_ninth_bit, tx_byte}; // [RQ15]
                     next_s.tx_busy = 1'b1;                                // [RQ2]
                     next_s.tx_count = `BIT_CNT_ZERO;
                  end
                  else if (!s.tx_buffer_full)
                  begin
                     next_s.tx_buffer.data = {s.transmit_ninth_bit, tx_byte}; // [RQ17]
                     next_s.tx_buffer_full = 1'b1;
                     next_s.transmit_flag = 1'b0;                          // [RQ15]
                  end
               end
               default:
                  next_s.bresp = `RESP_SLVERR;
            endcase
         end
      end

      // ****************************************
      // bus read
      // ****************************************
      rd_go = arvalid && !s.rvalid && !s.arready;
      if (rvalid && rready)
         next_s.rvalid = 1'b0;
      if (rd_go)
      begin
         next_s.arready = 1'b1;
         next_s.rvalid = 1'b1;
         next_s.rresp = `RESP_OKAY;
         next_s.rdata = 32'h0;
         case (araddr)
            `OFS_TRANSMIT_STATUS_CONTROL_CTRL:
               next_s.rdata[7:0] = {s.clock_source_select, s.transmit_nine_bit,
                                    s.transmit_enable, s.sync_mode, 2'b00,
                                    !s.tx_busy, s.transmit_ninth_bit};
            `OFS_RECEIVE_STATUS_CONTROL_CTRL:
               // ninth bit of the top character, read before the data
               next_s.rdata[7:0] = {s.serial_port_enable, s.receive_nine_bit,
                                    s.single_receive_enable, s.continuous_receive_enable,
                                    2'b00, s.overrun_error, s.rx_fifo[0].data[8]}; // [RQ8]
            `OFS_BAUD_CTRL:
               next_s.rdata[23:0] = {2'b00, s.transmit_flag, s.rx_level != 2'h0,
                                     s.global_int_enable, s.peripheral_int_enable,
                                     s.transmit_int_enable, s.receive_int_enable,
                                     s.data_pin_select, 4'h0, s.clock_pin_select,
                                     2'b00, s.baud_control};
            `OFS_TX_DATA:
            begin
               // receive data read pops one character
               next_s.rdata[7:0] = s.rx_fifo[0].data[7:0];
               if (s.rx_level != 2'h0)
               begin
                  next_s.rx_fifo[0] = s.rx_fifo[1];                       // [RQ12]
                  next_s.rx_level = s.rx_level - 2'h1;                    // [RQ12]
               end
            end
            default:
               next_s.rresp = `RESP_SLVERR;
         endcase
      end

      // ****************************************
      // transmit shifter on link edges only
      // ****************************************
      next_s.clk_oe_n = 1'b1;                                           // [RQ22]
      next_s.data_oe_n = !tx_mode;
      if (tx_mode && s.tx_busy && lead_edge)                            // [RQ11] [RQ10]
      begin
         // lsb first, ninth bit last when enabled
         next_s.data_out = s.transmit_shift_reg[0];                     // [RQ24] [RQ20]
         next_s.transmit_shift_reg = {1'b0, s.transmit_shift_reg[8:1]};
         next_s.tx_count = s.tx_count + 4'h1;
      end
      if (tx_mode && s.tx_busy && trail_edge &&
          s.tx_count == (s.transmit_nine_bit ? `BITS_NINE : `BITS_EIGHT))
      begin
         next_s.tx_count = `BIT_CNT_ZERO;
         next_s.transmit_flag = 1'b1;                                   // [RQ16]
         if (s.tx_buffer_full)
         begin
            next_s.transmit_shift_reg = s.tx_buffer.data;               // [RQ16]
            next_s.tx_buffer_full = 1'b0;
         end
         else
            next_s.tx_busy = 1'b0;
      end

      // ****************************************
      // receive shifter, two-deep buffer
      // ****************************************
      rx_char = s.receive_shift_reg;
      if (rx_mode && !s.overrun_error && trail_edge)                    // [RQ11] [RQ6]
      begin
         rx_char = {s.dat_sync[1], s.receive_shift_reg[8:1]};           // [RQ24] [RQ20]
         next_s.receive_shift_reg = rx_char;
         next_s.rx_count = s.rx_count + 4'h1;
         if (s.rx_count + 4'h1 == char_bits)                            // [RQ13]
         begin
            next_s.rx_count = `BIT_CNT_ZERO;
            if (!s.receive_nine_bit)
               rx_char = {1'b0, rx_char[8:1]};
            if (next_s.rx_level == `FIFO_DEPTH)
               next_s.overrun_error = 1'b1;                             // [RQ23]
            else
            begin
               next_s.rx_fifo[next_s.rx_level[0]] = rx_char;            // [RQ6]
               next_s.rx_level = next_s.rx_level + 2'h1;                // [RQ7]
            end
         end
      end
      if (!rx_mode)
         next_s.rx_count = `BIT_CNT_ZERO;
      if (!s.continuous_receive_enable)
         next_s.overrun_error = 1'b0;                                   // [RQ9]

      // ****************************************
      // wake and interrupt request
      // ****************************************
      next_s.irq = (s.receive_int_enable && next_s.rx_level != 2'h0 ||  // [RQ7]
                    s.transmit_int_enable && next_s.transmit_flag) &&
                   s.peripheral_int_enable;
      // wake always resumes the core; vectoring needs global enable too
      next_s.wake = sleeping && next_s.irq;                             // [RQ13] [RQ14]
      next_s.irq = next_s.irq && s.global_int_enable;                   // [RQ14]

      // clearing the port enable empties both paths and clears overrun; control bits keep their values
      if (!s.serial_port_enable)                                        // [RQ9]
      begin
         next_s.rx_level = 2'h0;
         next_s.rx_count = `BIT_CNT_ZERO;
         next_s.tx_busy = 1'b0;
         next_s.tx_buffer_full = 1'b0;
         next_s.tx_count = `BIT_CNT_ZERO;
         next_s.overrun_error = 1'b0;
         next_s.transmit_flag = 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.transmit_flag <= 1'b1;
         s.clk_oe_n <= 1'b1;
         s.data_oe_n <= 1'b1;
      end
      else
         s <= next_s;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign irq = s.irq;
   assign wake_req = s.wake;
   assign clock_pin_o = 2'b00;
   assign clock_pin_oe_n = {2{s.clk_oe_n}};
   assign data_pin_o = {2{s.data_out}};
   assign data_pin_oe_n = {s.data_oe_n | !s.data_pin_select,
                           s.data_oe_n | s.data_pin_select};

endmodule : usart_clocked_slave

// file: verif/usart_clocked_slave_properties.sv
// Purpose: port-level checks of the clocked serial slave
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/10ps
module usart_clocked_slave_properties
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        wvalid,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [1:0]  rresp,
   input wire logic [1:0]  clock_pin_i,
   input wire logic [1:0]  clock_pin_oe_n,
   input wire logic [1:0]  data_pin_o,
   input wire logic [1:0]  data_pin_oe_n,
   input wire logic        sleeping,
   input wire logic        wake_req,
   input wire logic        irq
);
   // ******************
   // helper and checks
   // ******************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic       clk_q;
   logic [3:0] since_rise;

   // cycles since a leading link clock edge, saturating
   always_ff @(posedge aclk)
   begin
      clk_q <= |clock_pin_i;
      if (!aresetn)
         since_rise <= 4'hf;
      else if ((|clock_pin_i) && !clk_q)
         since_rise <= 4'h0;
      else if (since_rise != 4'hf)
         since_rise <= since_rise + 4'h1;
   end

   clk_driver_off_a: assert property (clock_pin_oe_n == 2'h3)
      else $error("clock pin driver enabled");
   one_data_pin_a: assert property (data_pin_oe_n != 2'h0)
      else $error("both data pins driven");
   data_on_rise_a: assert property ($changed(data_pin_o) |-> since_rise < 4'h8)
      else $error("data pin changed away from a leading edge");
   wake_asleep_a: assert property (!$past(sleeping) |-> !wake_req)
      else $error("wake request while awake");
   write_answer_a: assert property (awvalid && wvalid && !bvalid |-> ##[1:3] bvalid)
      else $error("write response late");
   read_answer_a: assert property (arvalid && !rvalid |-> ##[1:2] rvalid)
      else $error("read response late");
   write_done_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response held after handshake");
   read_done_a: assert property (rvalid && rready |=> !rvalid)
      else $error("read response held after handshake");
   reset_quiet_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq && !wake_req)
      else $error("outputs active out of reset");

   cover property ($rose(wake_req));
   cover property ($rose(irq));
   cover property (rvalid && rresp == 2'h2);
endmodule : usart_clocked_slave_properties

bind usart_clocked_slave usart_clocked_slave_properties usart_clocked_slave_properties_inst
(
   .aclk, .aresetn, .awvalid, .wvalid, .bvalid, .bready, .arvalid, .rvalid, .rready, .rresp,
   .clock_pin_i, .clock_pin_oe_n, .data_pin_o, .data_pin_oe_n, .sleeping, .wake_req, .irq
);

// file: verif/link_master_model.sv
// Purpose: external synchronous master clocking the serial slave
// Assumes: clock idles low; leading edge rising, trailing edge falling
// Notes:   spare pins carry a parked clock and inverted data
`timescale 1ns/10ps
module link_master_model
(
   input  wire logic       sel,
   input  wire logic [1:0] wire_dat,
   output logic      [1:0] clk_line,
   output logic      [1:0] dat_line
);
   logic clk_lvl = 1'b0;
   logic dat_lvl = 1'b0;

   // a slave listening on the wrong pin sees no clock and wrong data
   assign clk_line = sel ? {clk_lvl, 1'b0} : {1'b0, clk_lvl};
   assign dat_line = sel ? {dat_lvl, ~dat_lvl} : {~dat_lvl, dat_lvl};

   task automatic xfer(input logic [8:0] tx, input int n, input int slow,
                       output logic [8:0] rx);
      rx = 9'h0;
      #10;
      for (int i = 0; i < n; i++)
      begin
         clk_lvl = 1'b1;
         dat_lvl = tx[i];
         #100;
         clk_lvl = 1'b0;
         rx[i] = wire_dat[sel];
         #(100 + slow);
      end
      // released line must not keep the last bit
      dat_lvl = ~dat_lvl;
   endtask : xfer
endmodule : link_master_model

// file: verif/usart_clocked_slave_tb_top.sv
// Purpose: self-checking bench of the clocked serial slave
// Assumes: link master model on the pins, axi4-lite tasks on the registers
// Notes:   every path ends in conclude
`timescale 1ns/10ps
module usart_clocked_slave_tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [3:0]  awaddr = 4'h0;
   logic [3:0]  araddr = 4'h0;
   logic [3:0]  wstrb = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        sleeping = 1'b0;
   logic        sel = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, wake_req, irq;
   logic [31:0] rdata;
   logic [1:0]  bresp, rresp, clock_pin_i, clock_pin_o, clock_pin_oe_n;
   logic [1:0]  data_pin_i, data_pin_o, data_pin_oe_n, m_clk, m_dat;
   logic [8:0]  rx;
   int          fail_count = 0;
   int          comparisons = 0;
   int          cycles = 0;

   always #12.5 aclk = ~aclk;

   // wire level from every driver's enable
   assign clock_pin_i = (~clock_pin_oe_n & clock_pin_o) | (clock_pin_oe_n & m_clk);
   assign data_pin_i  = (~data_pin_oe_n & data_pin_o) | (data_pin_oe_n & m_dat);

   usart_clocked_slave usart_clocked_slave_inst
   (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .clock_pin_i, .clock_pin_o, .clock_pin_oe_n, .data_pin_i, .data_pin_o,
      .data_pin_oe_n, .sleeping, .wake_req, .irq
   );

   link_master_model link_master_model_inst
   (
      .sel, .wire_dat(data_pin_i), .clk_line(m_clk), .dat_line(m_dat)
   );

   // ******************
   // tasks
   // ******************
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   // read, mask and compare; also checks the response code
   task automatic rc(input string what, input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] exp, input logic [1:0] resp);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(what, rdata & m, exp);
      chk("read response", 32'(rresp), 32'(resp));
   endtask : rc

   // one character, then time for the flags to settle
   task automatic lk(input logic [8:0] tx, input int n, input int slow);
      link_master_model_inst.xfer(tx, n, slow, rx);
      repeat (8) @(posedge aclk);
   endtask : lk

   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end

   // ******************
   // sequence
   // ******************
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rc("flags at reset", 4'h8, 32'h003f_0000, 32'h0020_0000, 2'h0);
      chk("clock driver", 32'(clock_pin_oe_n), 32'h3);
      rc("unmapped", 4'h2, 32'h0, 32'h0, 2'h2);
      wr(4'h4, 32'h80);
      wr(4'h0, 32'h30);
      wr(4'h8, 32'h000e_0000);
      wr(4'hc, 32'ha5);
      wr(4'hc, 32'h3c);
      rc("tx flag filled", 4'h8, 32'h0020_0000, 32'h0, 2'h0);
      chk("data driver", 32'(data_pin_oe_n), 32'h2);
      sleeping <= 1'b1;
      lk(9'h0, 8, 0);
      chk("tx char a", 32'(rx), 32'h0a5);
      chk("tx wake", 32'(wake_req), 32'h1);
      chk("tx irq", 32'(irq), 32'h1);
      lk(9'h0, 8, 150);
      chk("tx char b", 32'(rx), 32'h03c);
      wr(4'h0, 32'h71);
      wr(4'hc, 32'h0f);
      wr(4'hc, 32'h33);
      rc("tx flag again", 4'h8, 32'h0020_0000, 32'h0, 2'h0);
      lk(9'h0, 9, 0);
      chk("nine bit a", 32'(rx), 32'h10f);
      lk(9'h0, 9, 0);
      chk("nine bit b", 32'(rx), 32'h133);
      wr(4'h0, 32'h10);
      wr(4'h4, 32'hb0);
      wr(4'h8, 32'h000d_0000);
      chk("rx data driver", 32'(data_pin_oe_n), 32'h3);
      lk(9'h011, 8, 0);
      chk("rx wake", 32'(wake_req), 32'h1);
      chk("rx irq", 32'(irq), 32'h1);
      lk(9'h022, 8, 0);
      lk(9'h033, 8, 0);
      rc("overrun", 4'h4, 32'h2, 32'h2, 2'h0);
      rc("rx char 1", 4'hc, 32'hff, 32'h11, 2'h0);
      rc("rx flag one left", 4'h8, 32'h0010_0000, 32'h0010_0000, 2'h0);
      rc("rx char 2", 4'hc, 32'hff, 32'h22, 2'h0);
      rc("rx flag empty", 4'h8, 32'h0010_0000, 32'h0, 2'h0);
      wr(4'h4, 32'h80);
      rc("overrun cleared", 4'h4, 32'h2, 32'h0, 2'h0);
      sel <= 1'b1;
      wr(4'h8, 32'h0000_8400);
      wr(4'h4, 32'hd0);
      lk(9'h1c3, 9, 0);
      chk("masked irq", 32'(irq), 32'h0);
      rc("rx ninth", 4'h4, 32'h1, 32'h1, 2'h0);
      rc("rx nine low", 4'hc, 32'hff, 32'hc3, 2'h0);
      wr(4'h0, 32'h0);
      lk(9'h055, 8, 0);
      rc("no async shift", 4'h8, 32'h0010_0000, 32'h0, 2'h0);
      conclude();
   end
endmodule : usart_clocked_slave_tb_top
